//--- core/i2c_slave_with_timeout.sv
// I2C slave core with shared data buffer, SCL hold and stall time-out.
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_defines.svh"
module i2c_slave_with_timeout (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire i2c_slave_pkg::bus_req_t i_bus,
  output logic [7:0] o_rdata,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_low_speed_rc_clock,
  output i2c_slave_pkg::pin_drv_t o_pins,
  output logic o_irq
);
  import i2c_slave_pkg::*;

  // ==========================================================
  // Core state
  // ==========================================================
  typedef struct packed {
    fsm_t fsm;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] data;
    logic [7:0] own_addr;
    logic [7:0] mode;
    logic transfer_complete_flag;
    logic address_match_flag;
    logic bus_busy_flag;
    logic transmit_select_bit;
    logic ack_to_send_bit;
    logic master_read_request_flag;
    logic iamwu;
    logic received_ack_flag;
    logic toen;
    logic tof;
    logic [5:0] tos;
    logic trun;
    logic [4:0] tdiv;
    logic [5:0] tcnt;
    pin_drv_t drv;
    logic irq;
    logic [7:0] rdata;
  } core_t;

  core_t st;
  core_t next_st;

  // ==========================================================
  // Input synchronisers
  // ==========================================================
  logic scl_m, scl_s, scl_p;
  logic sda_m, sda_s, sda_p;
  logic rc_m, rc_s, rc_p;

  // The first stage of each chain feeds only the second stage.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
      rc_m <= 1'b0;
      rc_s <= 1'b0;
      rc_p <= 1'b0;
    end else begin
      scl_m <= i_scl;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= i_sda;
      sda_s <= sda_m;
      sda_p <= sda_s;
      rc_m <= i_low_speed_rc_clock;
      rc_s <= rc_m;
      rc_p <= rc_s;
    end
  end

  // ==========================================================
  // Bus events
  // ==========================================================
  logic scl_rise, scl_fall, start_seen, stop_seen, rc_rise;

  // Conditions are judged on the second and third stages only.
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_seen = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_seen = scl_s & scl_p & ~sda_p & sda_s;
  assign rc_rise = rc_s & ~rc_p;

  // ==========================================================
  // Helpers
  // ==========================================================
  // Reset image of the whole core; data and address storage come up zero, mode at MODE_POR.
  function automatic core_t core_por();
    core_t c;
    c = '0;
    c.fsm = ST_IDLE;
    c.mode = `MODE_POR;
    c.transfer_complete_flag = 1'b1;
    c.received_ack_flag = 1'b1;
    return c;
  endfunction : core_por

  // Puts the status register back to its power-on value.
  function automatic core_t status_por(input core_t c);
    core_t r;
    r = c;
    r.transfer_complete_flag = 1'b1;
    r.address_match_flag = 1'b0;
    r.bus_busy_flag = 1'b0;
    r.transmit_select_bit = 1'b0;
    r.ack_to_send_bit = 1'b0;
    r.master_read_request_flag = 1'b0;
    r.iamwu = 1'b0;
    r.received_ack_flag = 1'b1;
    return r;
  endfunction : status_por

  // Register read multiplexer; unmapped offsets read zero.
  function automatic logic [7:0] reg_read(input core_t c, input logic [2:0] a);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `OFS_MODE: v = {c.mode[7:1], 1'b0};
      `OFS_CTRL: v = {c.transfer_complete_flag, c.address_match_flag, c.bus_busy_flag, c.transmit_select_bit, c.ack_to_send_bit, c.master_read_request_flag, c.iamwu, c.received_ack_flag};
      `OFS_DATA: v = c.data;
      `OFS_ADDR: v = c.own_addr;
      `OFS_TIMER: v = {c.toen, c.tof, c.tos};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // ==========================================================
  // Next-state logic
  // ==========================================================
  logic active, wr_data, rd_data, tick, overflow;

  assign active = (st.mode[7:5] == `MODE_I2C) && st.mode[`MODE_EN_BIT];
  assign wr_data = i_bus.wr && (i_bus.addr == `OFS_DATA);
  assign rd_data = i_bus.rd && (i_bus.addr == `OFS_DATA);
  assign tick = rc_rise && (st.tdiv == `LOW_SPEED_RC_CLOCK_DIV_LAST);
  assign overflow = active && st.trun && st.toen && tick && !scl_fall
                    && (st.tcnt == st.tos);

  always_comb begin
    next_st = st;
    next_st.irq = 1'b0;
    next_st.rdata = 8'h00;

    // Register port: read data stands one cycle after the strobe.
    if (i_bus.rd) begin
      next_st.rdata = reg_read(st, i_bus.addr);
    end
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        `OFS_MODE: next_st.mode = {i_bus.wdata[7:1], 1'b0};
        `OFS_CTRL: begin
          next_st.transmit_select_bit = i_bus.wdata[4];
          next_st.ack_to_send_bit = i_bus.wdata[3];
          next_st.iamwu = i_bus.wdata[1];
        end
        `OFS_DATA: next_st.data = i_bus.wdata;
        // One storage serves as own address and SPI second control.
        `OFS_ADDR: next_st.own_addr = i_bus.wdata;
        `OFS_TIMER: begin
          next_st.toen = i_bus.wdata[`TIMER_EN_BIT];
          next_st.tof = i_bus.wdata[`TIMER_FLAG_BIT];
          next_st.tos = i_bus.wdata[5:0];
        end
        default: ;
      endcase
    end

    // The RC clock runs free, so the divide-by-32 never stops.
    if (rc_rise) begin
      next_st.tdiv = st.tdiv + 5'h01;
    end

    // Stall timer: cleared by SCL falling, advanced by the divided tick.
    if (st.trun) begin
      if (scl_fall) begin
        next_st.tcnt = 6'h00;
      end else if (tick) begin
        next_st.tcnt = st.tcnt + 6'h01;
      end
    end

    if (!active) begin
      // Disabled: flags sit at defaults, the pins are released.
      next_st.fsm = ST_IDLE;
      next_st.drv = '0;
      next_st.transfer_complete_flag = 1'b1;
      next_st.address_match_flag = 1'b0;
      next_st.bus_busy_flag = 1'b0;
      next_st.master_read_request_flag = 1'b0;
      next_st.received_ack_flag = 1'b1;
      next_st.trun = 1'b0;
    end else if (start_seen) begin
      // A repeated START is honoured from any state.
      next_st.bus_busy_flag = 1'b1;
      next_st.fsm = ST_ADDR;
      next_st.cnt = 4'h0;
      next_st.transfer_complete_flag = 1'b0;
      next_st.drv = '0;
    end else if (stop_seen) begin
      next_st.bus_busy_flag = 1'b0;
      next_st.fsm = ST_IDLE;
      next_st.drv = '0;
      next_st.trun = 1'b0;
    end else begin
      unique case (st.fsm)
        ST_IDLE: ;
        ST_ADDR: begin
          if (scl_rise) begin
            next_st.shift = {st.shift[6:0], sda_s};
            next_st.cnt = st.cnt + 4'h1;
          end else if (scl_fall && st.cnt == `BYTE_BITS) begin
            if (st.shift[7:1] == st.own_addr[7:1]) begin
              next_st.address_match_flag = 1'b1;
              next_st.master_read_request_flag = st.shift[0];
              next_st.irq = 1'b1;
              next_st.drv.sda_oe = 1'b1;
              next_st.fsm = ST_ACK_ADDR;
              next_st.trun = st.toen;
              next_st.tcnt = 6'h00;
            end else begin
              next_st.fsm = ST_WAIT_STOP;
            end
          end
        end
        ST_ACK_ADDR: begin
          if (scl_fall) begin
            next_st.drv.sda_oe = 1'b0;
            next_st.drv.scl_oe = 1'b1;
            next_st.fsm = ST_HOLD;
          end
        end
        ST_HOLD: begin
          // SCL stays low until firmware services the buffer.
          if (st.transmit_select_bit && wr_data) begin
            next_st.shift = i_bus.wdata;
            next_st.drv.sda_oe = ~i_bus.wdata[7];
            next_st.drv.scl_oe = 1'b0;
            next_st.cnt = 4'h0;
            next_st.transfer_complete_flag = 1'b0;
            next_st.address_match_flag = 1'b0;
            next_st.fsm = ST_TX;
          end else if (!st.transmit_select_bit && rd_data) begin
            next_st.drv.scl_oe = 1'b0;
            next_st.cnt = 4'h0;
            next_st.transfer_complete_flag = 1'b0;
            next_st.address_match_flag = 1'b0;
            next_st.fsm = ST_RX;
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            next_st.shift = {st.shift[6:0], sda_s};
            next_st.cnt = st.cnt + 4'h1;
          end else if (scl_fall && st.cnt == `BYTE_BITS) begin
            // A byte landing in the same cycle as a software write wins.
            next_st.data = st.shift;
            next_st.transfer_complete_flag = 1'b1;
            next_st.irq = 1'b1;
            next_st.drv.sda_oe = ~st.ack_to_send_bit;
            next_st.fsm = ST_ACK_RX;
          end
        end
        ST_ACK_RX: begin
          if (scl_fall) begin
            next_st.drv.sda_oe = 1'b0;
            next_st.drv.scl_oe = 1'b1;
            next_st.fsm = ST_HOLD;
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == `BYTE_LAST) begin
              next_st.drv.sda_oe = 1'b0;
              next_st.fsm = ST_ACK_TX;
            end else begin
              next_st.shift = {st.shift[6:0], 1'b0};
              next_st.drv.sda_oe = ~st.shift[6];
            end
          end
        end
        ST_ACK_TX: begin
          if (scl_rise) begin
            next_st.received_ack_flag = sda_s;
          end else if (scl_fall) begin
            next_st.transfer_complete_flag = 1'b1;
            next_st.irq = 1'b1;
            if (st.received_ack_flag) begin
              // No ACK: SDA stays released until the master ends with STOP.
              next_st.fsm = ST_WAIT_STOP;
            end else begin
              next_st.drv.scl_oe = 1'b1;
              next_st.fsm = ST_HOLD;
            end
          end
        end
        ST_WAIT_STOP: begin
          next_st.drv = '0;
        end
        default: begin
          next_st.fsm = ST_IDLE;
          next_st.drv = '0;
        end
      endcase
    end

    // Time-out overrides everything but the data, address and mode storage and the time-out setting.
    if (overflow) begin
      next_st = status_por(next_st);
      next_st.fsm = ST_IDLE;
      next_st.drv = '0;
      next_st.trun = 1'b0;
      next_st.toen = 1'b0;
      next_st.tof = 1'b1;
      next_st.irq = 1'b1;
    end
  end

  // ==========================================================
  // State register
  // ==========================================================
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st <= core_por();
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // All outputs are fields of the state register.
  assign o_rdata = st.rdata;
  assign o_pins = st.drv;
  assign o_irq = st.irq;

endmodule : i2c_slave_with_timeout
`default_nettype wire

//--- core/i2c_slave_defines.svh
// Register offsets, field positions, reset values and counts for the I2C slave core.
// Functional notes
// - After START, shift seven address bits in and compare with the own address.
// - Own address register bits 7..1 hold address bits 6..0, used for compare.
// - Own address register bit 0 is plain read/write storage with no bus use.
// - Own address register shares its location with the SPI second control register.
// - START is SDA falling while SCL high; it sets the bus busy flag.
// - Address arrives MSB first; the eighth bit goes to the read request flag.
// - On match set address match flag, request interrupt, drive ACK low on ninth bit.
// - After match hold SCL low until a data write (transmit) or dummy read (receive).
// - Data bytes are eight bits, MSB first, following the address acknowledge.
// - When receiving, drive the ack-to-send bit onto SDA on every ninth clock.
// - When transmitting, capture master ACK; on no ACK release SDA and await STOP.
// - Received bytes land in the data buffer; transmit bytes come from it.
// - One interrupt for address match and byte completion; match flag tells them apart.
// - Stall timer starts on START plus match, clears on SCL fall, stops on STOP.
// - On overflow timer halts, its enable clears, its flag sets, interrupt requested.
// - Time-out resets bus logic and status register; data, address, mode registers kept.
// - The stall timer flag stays set until firmware clears it.
// - Time-out is (setting+1) times 32 low-speed RC periods, 64 settings.
// - Mode field value 110 selects the I2C slave function.
// - Transfer complete is low while a byte moves, high with interrupt at its end; the core keeps it low at the address match interrupt.
// - Bus busy clears on STOP, SDA rising while SCL high.
`ifndef I2C_SLAVE_DEFINES_SVH
`define I2C_SLAVE_DEFINES_SVH
`define OFS_MODE 3'h0
`define OFS_CTRL 3'h1
`define OFS_DATA 3'h2
`define OFS_ADDR 3'h3
`define OFS_TIMER 3'h4
`define MODE_I2C 3'h6
`define MODE_EN_BIT 1
`define MODE_POR 8'hE0
`define TIMER_EN_BIT 7
`define TIMER_FLAG_BIT 6
`define LOW_SPEED_RC_CLOCK_DIV_LAST 5'h1F
`define BYTE_BITS 4'h8
`define BYTE_LAST 4'h7
`endif

//--- core/i2c_slave_pkg.sv
// Types shared by the I2C slave core and its users.
package i2c_slave_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ADDR = 4'h3,
    ST_HOLD = 4'h2,
    ST_RX = 4'h6,
    ST_ACK_RX = 4'h7,
    ST_TX = 4'h5,
    ST_ACK_TX = 4'h4,
    ST_WAIT_STOP = 4'hC
  } fsm_t;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;
  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } pin_drv_t;
endpackage : i2c_slave_pkg

//--- sim/i2c_slave_props.sv
// Port checker for the I2C slave core.
`timescale 1ns/10ps
`default_nettype none
module i2c_slave_props (
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire i2c_slave_pkg::bus_req_t i_bus,
  input wire logic [7:0] o_rdata,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_low_speed_rc_clock,
  input wire i2c_slave_pkg::pin_drv_t o_pins,
  input wire logic o_irq
);
  import i2c_slave_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  // ================================================================
  // Cycles since raw SCL fell; the core answers after its sync stages.
  logic scl_q;
  logic [7:0] since_fall;
  logic [7:0] next_since_fall;
  always_comb begin
    next_since_fall = (since_fall == 8'hFF) ? since_fall : since_fall + 8'h01;
    if (scl_q && !i_scl) begin
      next_since_fall = 8'h00;
    end
  end
  always_ff @(posedge i_sys_clk) begin
    scl_q <= i_scl;
    since_fall <= i_sys_rst ? 8'hFF : next_since_fall;
  end
  // ================================================================
  // STOP on the raw lines.
  sequence stop_seen;
    i_scl && $rose(i_sda);
  endsequence
  a_rdata_read_slot: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
    else $error("read data outside its slot");
  a_pins_drive_low: assert property (!o_pins.scl_o && !o_pins.sda_o)
    else $error("pin driven high");
  a_irq_one_cycle: assert property (o_irq |=> !o_irq)
    else $error("interrupt longer than one cycle");
  a_ack_after_fall: assert property ($rose(o_pins.sda_oe) |-> since_fall <= 8'h06
    || $past(i_bus.wr) || $past(i_bus.wr, 2))
    else $error("data drive not tied to SCL fall");
  a_sda_scl_low: assert property ($changed(o_pins.sda_oe) |-> !i_scl || o_irq
    || $past(o_irq) || $past(i_bus.wr) || $past(i_bus.wr, 2))
    else $error("SDA moved while SCL high");
  a_hold_after_fall: assert property ($rose(o_pins.scl_oe) |-> since_fall <= 8'h06)
    else $error("SCL hold not after a fall");
  a_hold_release: assert property ($fell(o_pins.scl_oe) |-> $past(i_bus.wr)
    || $past(i_bus.rd) || $past(i_bus.wr, 2) || $past(i_bus.rd, 2) || o_irq || $past(o_irq))
    else $error("SCL released without service");
  a_stop_quiet: assert property (stop_seen |-> ##3 (!o_pins.scl_oe && !o_pins.sda_oe)[*4])
    else $error("pins driven after STOP");
endmodule : i2c_slave_props
bind i2c_slave_with_timeout i2c_slave_props u_props (.i_sys_clk(i_sys_clk),
  .i_sys_rst(i_sys_rst), .i_bus(i_bus), .o_rdata(o_rdata), .i_scl(i_scl), .i_sda(i_sda),
  .i_low_speed_rc_clock(i_low_speed_rc_clock), .o_pins(o_pins), .o_irq(o_irq));
`default_nettype wire

//--- sim/i2c_master_model.sv
// Behavioural I2C bus master with open-drain enables.
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl_oe,
  output logic o_sda_oe,
  output logic o_hang
);
  localparam int HALF = 400;
  // Lines start released.
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
    o_hang = 1'b0;
  end
  // ================================================================
  // The slave may stretch SCL; give up after 50 us and flag a hang.
  task automatic scl_up();
    int n;
    o_scl_oe = 1'b0;
    for (n = 0; n < 2000 && !i_scl; n++) #25;
    if (!i_scl) o_hang = 1'b1;
  endtask : scl_up
  task automatic start();
    o_sda_oe = 1'b0;
    scl_up();
    #HALF o_sda_oe = 1'b1;
    #HALF o_scl_oe = 1'b1;
    #100;
  endtask : start
  task automatic stop();
    o_sda_oe = 1'b1;
    #HALF scl_up();
    #HALF o_sda_oe = 1'b0;
    #HALF;
  endtask : stop
  // Data moves 100 ns after SCL falls, so no edge looks like START or STOP.
  task automatic put_bit(input logic b);
    o_sda_oe = ~b;
    #HALF scl_up();
    #HALF o_scl_oe = 1'b1;
    #100;
  endtask : put_bit
  task automatic get_bit(output logic b);
    o_sda_oe = 1'b0;
    #HALF scl_up();
    #(HALF / 2) b = i_sda;
    #(HALF / 2) o_scl_oe = 1'b1;
    #100;
  endtask : get_bit
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack);
  endtask : wr_byte
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(ack);
  endtask : rd_byte
endmodule : i2c_master_model
`default_nettype wire

//--- sim/i2c_slave_with_timeout_tb_top.sv
// Self-checking bench for the I2C slave core with stall time-out.
`timescale 1ns/10ps
`default_nettype none
`include "i2c_slave_defines.svh"
module i2c_slave_with_timeout_tb_top;
  import i2c_slave_pkg::*;
  logic i_sys_clk, i_sys_rst, rc_clk, irq, m_scl_oe, m_sda_oe, hang, a;
  bus_req_t bus;
  pin_drv_t pins;
  logic [7:0] rdata, irq_n, v;
  int err_total, checks;
  // Pull-ups: a line is low while any party enables its driver.
  wire logic scl = ~(m_scl_oe | (pins.scl_oe === 1'b1));
  wire logic sda = ~(m_sda_oe | (pins.sda_oe === 1'b1));
  i2c_slave_with_timeout dut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .i_bus(bus),
    .o_rdata(rdata), .i_scl(scl), .i_sda(sda), .i_low_speed_rc_clock(rc_clk),
    .o_pins(pins), .o_irq(irq));
  i2c_master_model m (.i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe),
    .o_hang(hang));
  // The RC clock runs free at an eighth of the system clock rate.
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  initial begin
    rc_clk = 1'b0;
    forever #100 rc_clk = ~rc_clk;
  end
  // Interrupt pulses are counted, so none is missed between checks.
  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) irq_n <= 8'h00;
    else if (irq === 1'b1) irq_n <= irq_n + 8'h01;
  end
  // ================================================================
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] ad, input logic [7:0] d);
    @(posedge i_sys_clk);
    bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_sys_clk);
    bus.wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [2:0] ad, output logic [7:0] d);
    @(posedge i_sys_clk);
    bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_sys_clk);
    bus.rd <= 1'b0;
    @(negedge i_sys_clk);
    d = rdata;
  endtask : rd
  task automatic rdchk(input logic [2:0] ad, input logic [7:0] mk, input logic [7:0] exp);
    rd(ad, v);
    chk(v & mk, exp);
  endtask : rdchk
  task automatic summarize();
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  // ================================================================
  task automatic t_regs();
    rdchk(`OFS_MODE, 8'hFF, `MODE_POR);
    rdchk(`OFS_CTRL, 8'hFF, 8'h81);
    rdchk(`OFS_TIMER, 8'hFF, 8'h00);
    wr(`OFS_ADDR, 8'h55);
    wr(3'h5, 8'hFF);
    rdchk(`OFS_ADDR, 8'hFF, 8'h55);
    rdchk(3'h5, 8'hFF, 8'h00);
  endtask : t_regs
  // Mode 111 must ignore a matching address; 110 turns the slave on.
  task automatic t_off();
    wr(`OFS_MODE, 8'hE2);
    m.start();
    m.wr_byte(8'h54, a);
    chk({7'h00, a}, 8'h01);
    m.stop();
    wr(`OFS_MODE, 8'hC2);
    rdchk(`OFS_MODE, 8'hFF, 8'hC2);
  endtask : t_off
  task automatic t_miss();
    logic [7:0] n0;
    n0 = irq_n;
    m.start();
    m.wr_byte(8'h56, a);
    chk({7'h00, a}, 8'h01);
    chk(irq_n, n0);
    m.stop();
  endtask : t_miss
  task automatic t_rx();
    logic [7:0] n0;
    n0 = irq_n;
    m.start();
    rdchk(`OFS_CTRL, 8'h20, 8'h20);
    m.wr_byte(8'h54, a);
    chk({7'h00, a}, 8'h00);
    chk(irq_n, n0 + 8'h01);
    rdchk(`OFS_CTRL, 8'h7C, 8'h60);
    chk({7'h00, pins.scl_oe}, 8'h01);
    rd(`OFS_DATA, v);
    m.wr_byte(8'hC5, a);
    chk({7'h00, a}, 8'h00);
    chk(irq_n, n0 + 8'h02);
    rdchk(`OFS_CTRL, 8'hC0, 8'h80);
    wr(`OFS_CTRL, 8'h08);
    rdchk(`OFS_DATA, 8'hFF, 8'hC5);
    m.wr_byte(8'h3A, a);
    chk({7'h00, a}, 8'h01);
    rdchk(`OFS_DATA, 8'hFF, 8'h3A);
    wr(`OFS_CTRL, 8'h00);
    m.stop();
    rdchk(`OFS_CTRL, 8'h20, 8'h00);
  endtask : t_rx
  task automatic t_tx();
    m.start();
    m.wr_byte(8'h55, a);
    chk({7'h00, a}, 8'h00);
    rdchk(`OFS_CTRL, 8'h04, 8'h04);
    wr(`OFS_CTRL, 8'h10);
    wr(`OFS_DATA, 8'h96);
    m.rd_byte(1'b0, v);
    chk(v, 8'h96);
    rdchk(`OFS_CTRL, 8'h81, 8'h80);
    wr(`OFS_DATA, 8'h5B);
    m.rd_byte(1'b1, v);
    chk(v, 8'h5B);
    rdchk(`OFS_CTRL, 8'h01, 8'h01);
    chk({7'h00, pins.sda_oe}, 8'h00);
    m.stop();
    wr(`OFS_CTRL, 8'h00);
  endtask : t_tx
  // Firmware never services the hold, so the stall timer must fire.
  task automatic t_stall();
    logic [7:0] n0;
    wr(`OFS_TIMER, 8'h80);
    n0 = irq_n;
    m.start();
    m.wr_byte(8'h54, a);
    for (int i = 0; i < 1000 && irq_n == n0 + 8'h01; i++) @(posedge i_sys_clk);
    chk(irq_n, n0 + 8'h02);
    if (irq_n !== n0 + 8'h02) summarize();
    rdchk(`OFS_CTRL, 8'hFF, 8'h81);
    rdchk(`OFS_TIMER, 8'hFF, 8'h40);
    rdchk(`OFS_MODE, 8'hFF, 8'hC2);
    rdchk(`OFS_ADDR, 8'hFF, 8'h55);
    chk({7'h00, pins.scl_oe}, 8'h00);
    rdchk(`OFS_TIMER, 8'hFF, 8'h40);
    wr(`OFS_TIMER, 8'h00);
    rdchk(`OFS_TIMER, 8'hFF, 8'h00);
    m.stop();
  endtask : t_stall
  // ================================================================
  initial begin
    bus = '0;
    i_sys_rst = 1'b1;
    err_total = 0;
    checks = 0;
    repeat (6) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_regs();
    t_off();
    t_miss();
    t_rx();
    t_tx();
    t_stall();
    chk({7'h00, hang}, 8'h00);
    summarize();
  end
  // A hang anywhere ends the run as a failure.
  initial begin
    repeat (80000) @(posedge i_sys_clk);
    err_total++;
    summarize();
  end
endmodule : i2c_slave_with_timeout_tb_top
`default_nettype wire
